// file: dv/action_command_filter_test.sv
// Self-checking testbench of the action command filter.
`timescale 1ns/100ps
module action_command_filter_test;
   logic        i_mclk = 1'h0;
   logic        i_reset = 1'h1;
   logic [3:0]  i_addr = 4'h0;
   logic [31:0] i_wdata = 32'h0;
   logic        i_wr = 1'h0;
   logic        i_rd = 1'h0;
   logic        i_ctrl_open = 1'h0;
   logic        fire = 1'h0;
   logic [31:0] dk = 32'h0, gk = 32'h0, gm = 32'h0;
   logic [31:0] o_rdata, m_dk, m_gk, m_gm, rv;
   logic        m_valid;
   logic [3:0]  o_action, o_soft_signal, seen_act, seen_soft;
   int          n_act, n_soft;
   int          fails = 0;
   int          checked = 0;

   always #4 i_mclk = ~i_mclk;

   action_command_filter dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_msg_valid(m_valid), .i_msg_device_key(m_dk),
      .i_msg_group_key(m_gk), .i_msg_group_mask(m_gm), .i_ctrl_open(i_ctrl_open),
      .o_action(o_action), .o_soft_signal(o_soft_signal));
   action_sender sender (.i_mclk(i_mclk), .i_reset(i_reset), .i_fire(fire), .i_dev_key(dk),
      .i_grp_key(gk), .i_grp_mask(gm), .o_msg_valid(m_valid), .o_msg_device_key(m_dk),
      .o_msg_group_key(m_gk), .o_msg_group_mask(m_gm));

   // ***************************************************************
   // Compare, bus and observation tasks
   // ***************************************************************
   task cmp32(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   task cmp4(input string name, input logic [3:0] exp, input logic [3:0] got);
      cmp32(name, {28'h0, exp}, {28'h0, got});
   endtask
   // Each access opens with an idle edge, so a strobe is never lowered and raised in one step
   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_mclk);
      i_addr <= a; i_wdata <= d; i_wr <= 1'h1;
      @(posedge i_mclk);
      i_wr <= 1'h0;
   endtask
   task rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge i_mclk);
      i_addr <= a; i_rd <= 1'h1;
      @(posedge i_mclk);
      i_rd <= 1'h0;
      @(negedge i_mclk);
      d = o_rdata;
   endtask
   // Gathers pulses over a window wide enough for either registered latency
   task watch;
      seen_act = 4'h0; seen_soft = 4'h0; n_act = 0; n_soft = 0;
      repeat (6) begin
         @(posedge i_mclk);
         seen_act |= o_action; seen_soft |= o_soft_signal;
         if (o_action != 4'h0) n_act++;
         if (o_soft_signal != 4'h0) n_soft++;
      end
   endtask
   task msg(input logic [31:0] d, input logic [31:0] k, input logic [31:0] m, input logic [3:0] exp);
      @(posedge i_mclk);
      dk <= d; gk <= k; gm <= m; fire <= 1'h1;
      @(posedge i_mclk);
      fire <= 1'h0;
      watch;
      cmp4("action", exp, seen_act);
      cmp32("action_cycles", (exp != 4'h0) ? 32'h1 : 32'h0, n_act);
   endtask

   // ***************************************************************
   // Scenarios
   // ***************************************************************
   task t_regs;
      rd(4'h5, rv); cmp32("queue_depth", 32'h0, rv);
      wr(4'h5, 32'hffffffff);
      rd(4'h5, rv); cmp32("queue_depth_ro", 32'h0, rv);
      wr(4'h0, 32'h12345678);
      rd(4'h0, rv); cmp32("device_key_rd", 32'h0, rv);
      rd(4'h9, rv); cmp32("unmapped", 32'h0, rv);
      rd(4'h8, rv); cmp32("status", 32'h1, rv);
   endtask
   // Keys 1,1,2,2 and one mask bit per action; read back in reverse to prove separate storage
   task t_slots;
      for (int i = 0; i < 4; i++) begin
         wr(4'h1, i); wr(4'h2, 32'h1 + (i >> 1)); wr(4'h3, 32'h1 << i);
      end
      for (int i = 3; i >= 0; i--) begin
         wr(4'h1, i);
         rd(4'h1, rv); cmp32("action_index", i, rv);
         rd(4'h2, rv); cmp32("group_key", 32'h1 + (i >> 1), rv);
         rd(4'h3, rv); cmp32("group_mask", 32'h1 << i, rv);
      end
   endtask
   task t_match;
      msg(32'h12345678, 32'h1, 32'hf, 4'h3);
      msg(32'h12345678, 32'h2, 32'h5, 4'h4);
      msg(32'h12345679, 32'h1, 32'hf, 4'h0);
      msg(32'h12345678, 32'h3, 32'hf, 4'h0);
      msg(32'h12345678, 32'h1, 32'hc, 4'h0);
   endtask
   task t_closed;
      i_ctrl_open <= 1'h0;
      msg(32'h12345678, 32'h1, 32'hf, 4'h0);
      rd(4'h8, rv); cmp32("status_closed", 32'h0, rv);
      wr(4'h4, 32'h1);
      rd(4'h4, rv); cmp32("mode", 32'h1, rv);
      msg(32'h12345678, 32'h2, 32'hf, 4'hc);
      wr(4'h4, 32'h0);
      msg(32'h12345678, 32'h2, 32'hf, 4'h0);
      i_ctrl_open <= 1'h1;
   endtask
   task t_soft;
      for (int i = 0; i < 4; i++) begin
         wr(4'h6, i);
         rd(4'h6, rv); cmp32("soft_index", i, rv);
         wr(4'h7, 32'h0);
         watch;
         cmp4("soft_signal", 4'h1 << i, seen_soft);
         cmp32("soft_cycles", 32'h1, n_soft);
         cmp4("no_action", 4'h0, seen_act);
      end
   endtask
   // Reset in mid-run must clear mode, index, keys and masks
   task t_reset;
      wr(4'h4, 32'h1);
      @(posedge i_mclk);
      i_reset <= 1'h1;
      repeat (3) @(posedge i_mclk);
      i_reset <= 1'h0;
      rd(4'h4, rv); cmp32("mode_after_reset", 32'h0, rv);
      rd(4'h1, rv); cmp32("index_after_reset", 32'h0, rv);
      rd(4'h2, rv); cmp32("key_after_reset", 32'h0, rv);
      rd(4'h3, rv); cmp32("mask_after_reset", 32'h0, rv);
      msg(32'h12345678, 32'h1, 32'hf, 4'h0);
   endtask

   task close_out;
      if (fails == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (12) @(posedge i_mclk);
      i_reset <= 1'h0;
      i_ctrl_open <= 1'h1;
      t_regs;
      t_slots;
      t_match;
      t_closed;
      t_soft;
      t_reset;
      close_out;
   end
   // Watchdog: the sequence needs well under 1000 cycles
   initial begin
      repeat (5000) @(posedge i_mclk);
      fails++;
      close_out;
   end
endmodule

// file: dv/action_sender.sv
// Model of the far-side sender that broadcasts action messages to the filter.
`timescale 1ns/100ps
module action_sender (
   input  wire logic        i_mclk,
   input  wire logic        i_reset,
   input  wire logic        i_fire,
   input  wire logic [31:0] i_dev_key,
   input  wire logic [31:0] i_grp_key,
   input  wire logic [31:0] i_grp_mask,
   output logic             o_msg_valid,
   output logic      [31:0] o_msg_device_key,
   output logic      [31:0] o_msg_group_key,
   output logic      [31:0] o_msg_group_mask
);
   // One message per fire cycle; outside it the fields flip each cycle so stale keys never match
   always @(posedge i_mclk) begin
      if (i_reset) begin
         o_msg_valid <= 1'h0;
         o_msg_device_key <= 32'h0;
         o_msg_group_key <= 32'h0;
         o_msg_group_mask <= 32'h0;
      end else if (i_fire) begin
         o_msg_valid <= 1'h1;
         o_msg_device_key <= i_dev_key;
         o_msg_group_key <= i_grp_key;
         o_msg_group_mask <= i_grp_mask;
      end else begin
         o_msg_valid <= 1'h0;
         o_msg_device_key <= ~o_msg_device_key;
         o_msg_group_key <= ~o_msg_group_key;
         o_msg_group_mask <= ~o_msg_group_mask;
      end
   end
endmodule

// file: hdl/action_command_filter.sv
// Action command filter: device key, per-action group filter, software pulses.
// Behaviour
// - Writing the software pulse command pulses the selected software signal.
// - Software signal pulses leave as trigger sources for any consumer.
// - A software signal index picks which software signal the command pulses.
// - Action signals leave as trigger sources, same as digital input lines.
// - A matching message raises the action signal of each matching action.
// - One device-wide key, write-only, validates incoming action commands.
// - No action signal unless device-wide key equals the message device key.
// - Message group mask AND configured mask must be non-zero.
// - Configured group key must equal the message group key.
// - Each action has its own readable, writable group mask.
// - Each action has its own readable, writable group key.
// - An action index selects which action the key and mask accesses reach.
// - Accept-when-closed on keeps commands flowing while control channel closed.
// - The scheduled queue depth reads back as a fixed, read-only value.
`timescale 1ns/100ps
`include "action_command_filter_params.svh"
module action_command_filter (
   input  wire logic                          i_mclk,
   input  wire logic                          i_reset,
   // Register port
   input  wire logic [`ACF_ADDR_W-1:0]        i_addr,
   input  wire logic [`ACF_DATA_W-1:0]        i_wdata,
   input  wire logic                          i_wr,
   input  wire logic                          i_rd,
   output logic      [`ACF_DATA_W-1:0]        o_rdata,
   // Received action message, one-cycle valid strobe
   input  wire logic                          i_msg_valid,
   input  wire logic [`ACF_KEY_W-1:0]         i_msg_device_key,
   input  wire logic [`ACF_KEY_W-1:0]         i_msg_group_key,
   input  wire logic [`ACF_KEY_W-1:0]         i_msg_group_mask,
   // Primary control channel state, same clock domain
   input  wire logic                          i_ctrl_open,
   // Trigger outputs
   output logic      [`ACF_NUM_ACTIONS-1:0]   o_action,
   output logic      [`ACF_NUM_SOFT-1:0]      o_soft_signal
);
   import action_command_filter_pkg::*;

   localparam int NA = `ACF_NUM_ACTIONS;
   localparam int NS = `ACF_NUM_SOFT;

   // ***************************************************************
   // Configuration registers
   // ***************************************************************
   logic [`ACF_KEY_W-1:0]        device_match_key;
   logic [`ACF_ACTION_IDX_W-1:0] action_index;
   logic [`ACF_SOFT_IDX_W-1:0]   soft_signal_index;
   logic                         accept_when_closed;
   logic [`ACF_KEY_W-1:0]        next_device_match_key;
   logic [`ACF_ACTION_IDX_W-1:0] next_action_index;
   logic [`ACF_SOFT_IDX_W-1:0]   next_soft_signal_index;
   logic                         next_accept_when_closed;
   logic                         soft_pulse_cmd;

   assign soft_pulse_cmd = i_wr && (i_addr == `ACF_REG_SOFT_PULSE);

   // Register writes; the device key has no read path
   always_comb begin
      next_device_match_key   = device_match_key;
      next_action_index       = action_index;
      next_soft_signal_index  = soft_signal_index;
      next_accept_when_closed = accept_when_closed;
      if (i_wr) begin
         unique case (i_addr)
            `ACF_REG_DEVICE_KEY:   next_device_match_key   = i_wdata;
            `ACF_REG_ACTION_INDEX: next_action_index       = i_wdata[`ACF_ACTION_IDX_W-1:0];
            `ACF_REG_SOFT_INDEX:   next_soft_signal_index  = i_wdata[`ACF_SOFT_IDX_W-1:0];
            `ACF_REG_MODE:         next_accept_when_closed = i_wdata[0];
            default:               next_device_match_key   = device_match_key;
         endcase
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         device_match_key   <= `ACF_KEY_RESET;
         action_index       <= '0;
         soft_signal_index  <= '0;
         accept_when_closed <= 1'b0;
      end else begin
         device_match_key   <= next_device_match_key;
         action_index       <= next_action_index;
         soft_signal_index  <= next_soft_signal_index;
         accept_when_closed <= next_accept_when_closed;
      end
   end

   // ***************************************************************
   // Per-action slots
   // ***************************************************************
   logic [NA-1:0]            slot_match;
   logic [`ACF_KEY_W-1:0]    slot_key  [NA];
   logic [`ACF_KEY_W-1:0]    slot_mask [NA];
   // Registered message fields; group key and mask shared by every slot, device key compared here
   logic [`ACF_KEY_W-1:0]    msg_device_key;
   logic [`ACF_KEY_W-1:0]    msg_group_key;
   logic [`ACF_KEY_W-1:0]    msg_group_mask;

   // The action index steers key and mask writes to one slot only
   for (genvar g = 0; g < NA; g++) begin : g_slot
      action_slot u_slot (
         .i_mclk           (i_mclk),
         .i_reset          (i_reset),
         .i_key_wr         (i_wr && i_addr == `ACF_REG_GROUP_KEY && action_index == (`ACF_ACTION_IDX_W)'(g)),
         .i_mask_wr        (i_wr && i_addr == `ACF_REG_GROUP_MASK && action_index == (`ACF_ACTION_IDX_W)'(g)),
         .i_wdata          (i_wdata),
         .i_msg_group_key  (msg_group_key),
         .i_msg_group_mask (msg_group_mask),
         .o_group_key      (slot_key[g]),
         .o_group_mask     (slot_mask[g]),
         .o_match          (slot_match[g])
      );
   end

   // ***************************************************************
   // Message intake
   // ***************************************************************
   // Messages are registered first so the wide compares sit in their own cycle
   msg_state_type          msg_state;
   msg_state_type          next_msg_state;
   logic [`ACF_KEY_W-1:0]  next_msg_device_key;
   logic [`ACF_KEY_W-1:0]  next_msg_group_key;
   logic [`ACF_KEY_W-1:0]  next_msg_group_mask;
   logic                   msg_allowed;
   logic                   device_ok;

   // A closed control channel blocks commands unless the mode says otherwise
   assign msg_allowed = i_msg_valid && (i_ctrl_open || accept_when_closed);
   assign device_ok   = (device_match_key == msg_device_key);

   always_comb begin
      next_msg_device_key = msg_device_key;
      next_msg_group_key  = msg_group_key;
      next_msg_group_mask = msg_group_mask;
      next_msg_state      = MSG_IDLE;
      if (msg_allowed) begin
         next_msg_device_key = i_msg_device_key;
         next_msg_group_key  = i_msg_group_key;
         next_msg_group_mask = i_msg_group_mask;
         next_msg_state      = MSG_CHECK;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         msg_state      <= MSG_IDLE;
         msg_device_key <= `ACF_KEY_RESET;
         msg_group_key  <= `ACF_KEY_RESET;
         msg_group_mask <= `ACF_KEY_RESET;
      end else begin
         msg_state      <= next_msg_state;
         msg_device_key <= next_msg_device_key;
         msg_group_key  <= next_msg_group_key;
         msg_group_mask <= next_msg_group_mask;
      end
   end

   // ***************************************************************
   // Trigger outputs
   // ***************************************************************
   logic [NA-1:0] next_action;
   logic [NS-1:0] next_soft_signal;

   // Both outputs are one-clock pulses, fit for any trigger input
   always_comb begin
      next_action      = '0;
      next_soft_signal = '0;
      unique case (msg_state)
         MSG_CHECK: next_action = device_ok ? slot_match : '0;
         MSG_IDLE:  next_action = '0;
         default:   next_action = '0;
      endcase
      if (soft_pulse_cmd) begin
         next_soft_signal[soft_signal_index] = 1'b1;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         o_action      <= '0;
         o_soft_signal <= '0;
      end else begin
         o_action      <= next_action;
         o_soft_signal <= next_soft_signal;
      end
   end

   // ***************************************************************
   // Register read port
   // ***************************************************************
   logic [`ACF_DATA_W-1:0] next_rdata;

   // Unmapped and write-only offsets read as zero
   always_comb begin
      next_rdata = `ACF_UNMAPPED_READ;
      if (i_rd) begin
         unique case (i_addr)
            `ACF_REG_ACTION_INDEX: next_rdata = {{(`ACF_DATA_W-`ACF_ACTION_IDX_W){1'b0}}, action_index};
            `ACF_REG_GROUP_KEY:    next_rdata = slot_key[action_index];
            `ACF_REG_GROUP_MASK:   next_rdata = slot_mask[action_index];
            `ACF_REG_MODE:         next_rdata = {{(`ACF_DATA_W-1){1'b0}}, accept_when_closed};
            `ACF_REG_QUEUE_DEPTH:  next_rdata = `ACF_QUEUE_DEPTH_VALUE;
            `ACF_REG_SOFT_INDEX:   next_rdata = {{(`ACF_DATA_W-`ACF_SOFT_IDX_W){1'b0}}, soft_signal_index};
            `ACF_REG_STATUS:       next_rdata = {{(`ACF_DATA_W-NA-1){1'b0}}, o_action, i_ctrl_open};
            default:               next_rdata = `ACF_UNMAPPED_READ;
         endcase
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         o_rdata <= '0;
      end else begin
         o_rdata <= next_rdata;
      end
   end

   // ***************************************************************
   // Assertions
   // ***************************************************************
   // Reference match built from the stored keys, so a broken slot compare cannot hide
   logic [NA-1:0] ref_match;
   always_comb begin
      ref_match = '0;
      for (int k = 0; k < NA; k++) begin
         ref_match[k] = (slot_key[k] == msg_group_key) && ((slot_mask[k] & msg_group_mask) != '0);
      end
   end

   sequence s_msg_in;
      i_msg_valid && (i_ctrl_open || accept_when_closed);
   endsequence

   sequence s_msg_refused;
      i_msg_valid && !i_ctrl_open && !accept_when_closed;
   endsequence

   a_closed_blocks: assert property (@(posedge i_mclk) disable iff (i_reset)
      s_msg_refused |=> ##1 (o_action == '0))
      else $error("action raised from a message refused while closed");

   a_msg_intake: assert property (@(posedge i_mclk) disable iff (i_reset)
      s_msg_in |=> (msg_state == MSG_CHECK))
      else $error("accepted message not checked");

   a_action_idle: assert property (@(posedge i_mclk) disable iff (i_reset)
      (msg_state == MSG_IDLE) |=> (o_action == '0))
      else $error("action raised without a message");

   a_key_gate: assert property (@(posedge i_mclk) disable iff (i_reset)
      (s_msg_in and (i_msg_device_key != device_match_key) and !i_wr) |=> ##1 (o_action == '0))
      else $error("action raised with wrong device key");

   a_action_single: assert property (@(posedge i_mclk) disable iff (i_reset)
      (o_action != '0) |=> ((o_action & $past(o_action)) == '0) || $past(msg_allowed, 2))
      else $error("action pulse longer than one cycle");

   a_soft_pulse: assert property (@(posedge i_mclk) disable iff (i_reset)
      soft_pulse_cmd |=> o_soft_signal[$past(soft_signal_index)])
      else $error("software pulse missing");

   a_soft_onehot: assert property (@(posedge i_mclk) disable iff (i_reset)
      $onehot0(o_soft_signal) and (!soft_pulse_cmd |=> (o_soft_signal == '0)))
      else $error("software pulse without command");

   a_soft_index_read: assert property (@(posedge i_mclk) disable iff (i_reset)
      (i_rd && i_addr == `ACF_REG_SOFT_INDEX) |=> (o_rdata[`ACF_SOFT_IDX_W-1:0] == $past(soft_signal_index)))
      else $error("software index read wrong");

   a_queue_depth: assert property (@(posedge i_mclk) disable iff (i_reset)
      (i_rd && i_addr == `ACF_REG_QUEUE_DEPTH) |=> o_rdata == `ACF_QUEUE_DEPTH_VALUE)
      else $error("queue depth read wrong");

   a_key_hidden: assert property (@(posedge i_mclk) disable iff (i_reset)
      (i_rd && i_addr == `ACF_REG_DEVICE_KEY) |=> o_rdata == '0)
      else $error("device key readable");

   a_key_write: assert property (@(posedge i_mclk) disable iff (i_reset)
      (i_wr && i_addr == `ACF_REG_DEVICE_KEY) |=> (device_match_key == $past(i_wdata)))
      else $error("device key write lost");

   a_slot_write: assert property (@(posedge i_mclk) disable iff (i_reset)
      (i_wr && i_addr == `ACF_REG_GROUP_MASK) |=> (slot_mask[$past(action_index)] == $past(i_wdata)))
      else $error("group mask write missed the indexed slot");

   a_index_read: assert property (@(posedge i_mclk) disable iff (i_reset)
      (i_rd && i_addr == `ACF_REG_ACTION_INDEX) |=> (o_rdata[`ACF_ACTION_IDX_W-1:0] == $past(action_index)))
      else $error("action index read wrong");

   a_mode_read: assert property (@(posedge i_mclk) disable iff (i_reset)
      (i_rd && i_addr == `ACF_REG_MODE) |=> (o_rdata == {{(`ACF_DATA_W-1){1'b0}}, $past(accept_when_closed)}))
      else $error("mode read wrong");

   a_status_read: assert property (@(posedge i_mclk) disable iff (i_reset)
      (i_rd && i_addr == `ACF_REG_STATUS) |=> (o_rdata == {{(`ACF_DATA_W-NA-1){1'b0}}, $past(o_action), $past(i_ctrl_open)}))
      else $error("status read wrong");

   a_match_raise: assert property (@(posedge i_mclk) disable iff (i_reset)
      (msg_state == MSG_CHECK && device_match_key == msg_device_key) |=> o_action == $past(ref_match))
      else $error("matching action not raised");
endmodule

// file: hdl/action_command_filter_params.svh
// Constants of the action command filter: register offsets, field widths, reset values.
`ifndef ACTION_COMMAND_FILTER_PARAMS_SVH
`define ACTION_COMMAND_FILTER_PARAMS_SVH

// ***************************************************************
// Sizes
// ***************************************************************
`define ACF_NUM_ACTIONS        4
`define ACF_ACTION_IDX_W       2
`define ACF_NUM_SOFT           4
`define ACF_SOFT_IDX_W         2
`define ACF_KEY_W              32
`define ACF_ADDR_W             4
`define ACF_DATA_W             32

// ***************************************************************
// Register offsets (word index on the plain port)
// ***************************************************************
`define ACF_REG_DEVICE_KEY     4'h0
`define ACF_REG_ACTION_INDEX   4'h1
`define ACF_REG_GROUP_KEY      4'h2
`define ACF_REG_GROUP_MASK     4'h3
`define ACF_REG_MODE           4'h4
`define ACF_REG_QUEUE_DEPTH    4'h5
`define ACF_REG_SOFT_INDEX     4'h6
`define ACF_REG_SOFT_PULSE     4'h7
`define ACF_REG_STATUS         4'h8

// ***************************************************************
// Reset values and fixed figures
// ***************************************************************
`define ACF_KEY_RESET          32'h0000_0000
`define ACF_QUEUE_DEPTH_VALUE  32'h0000_0000
`define ACF_UNMAPPED_READ      32'h0000_0000

`endif

// file: hdl/action_command_filter_pkg.sv
// Types shared by the action command filter files.
package action_command_filter_pkg;
   // Message intake state
   typedef enum logic [1:0] {
      MSG_IDLE  = 2'b01,
      MSG_CHECK = 2'b10
   } msg_state_type;
endpackage

// file: hdl/action_slot.sv
// One configured action: group key and mask storage plus its match term.
`timescale 1ns/100ps
`include "action_command_filter_params.svh"
module action_slot (
   input  wire logic                   i_mclk,
   input  wire logic                   i_reset,
   input  wire logic                   i_key_wr,
   input  wire logic                   i_mask_wr,
   input  wire logic [`ACF_KEY_W-1:0]  i_wdata,
   input  wire logic [`ACF_KEY_W-1:0]  i_msg_group_key,
   input  wire logic [`ACF_KEY_W-1:0]  i_msg_group_mask,
   output logic      [`ACF_KEY_W-1:0]  o_group_key,
   output logic      [`ACF_KEY_W-1:0]  o_group_mask,
   output logic                        o_match
);
   logic [`ACF_KEY_W-1:0] next_group_key;
   logic [`ACF_KEY_W-1:0] next_group_mask;

   // Per-action configuration, host writable and readable
   always_comb begin
      next_group_key  = i_key_wr  ? i_wdata : o_group_key;
      next_group_mask = i_mask_wr ? i_wdata : o_group_mask;
   end

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         o_group_key  <= `ACF_KEY_RESET;
         o_group_mask <= `ACF_KEY_RESET;
      end else begin
         o_group_key  <= next_group_key;
         o_group_mask <= next_group_mask;
      end
   end

   // Group filter: keys equal and masks overlap
   assign o_match = (o_group_key == i_msg_group_key)
                  && ((o_group_mask & i_msg_group_mask) != '0);
endmodule
